// File: logic/psr_pkg.sv
package psr_pkg;
    // register indices (byte addresses are word aligned: every offset is a multiple of 4)
    localparam logic [7:0] PSR_IDX_COMP_MULT = 8'h0F;
    localparam logic [7:0] PSR_IDX_MOVE_COMP = 8'h10;
    localparam logic [7:0] PSR_IDX_SYS_FLAGS = 8'h11;
    localparam logic [7:0] PSR_IDX_USER_INTERFACE_FLAGS = 8'h12;
    localparam int PSR_ADDR_W = 10;
    // byte address is four times the register index
    localparam logic [9:0] PSR_ADDR_COMP_MULT = {PSR_IDX_COMP_MULT, 2'b00};
    localparam logic [9:0] PSR_ADDR_MOVE_COMP = {PSR_IDX_MOVE_COMP, 2'b00};
    localparam logic [9:0] PSR_ADDR_SYS_FLAGS = {PSR_IDX_SYS_FLAGS, 2'b00};
    localparam logic [9:0] PSR_ADDR_USER_INTERFACE_FLAGS = {PSR_IDX_USER_INTERFACE_FLAGS, 2'b00};
    // system flag bit positions
    localparam int PSR_SYS_BUS_MODE = 7;
    localparam int PSR_SYS_TRACKING = 6;
    localparam int PSR_SYS_MOVE_ON = 5;
    localparam int PSR_SYS_NO_SYNC = 3;
    localparam int PSR_SYS_BASE_HALT = 2;
    localparam int PSR_SYS_RECAL = 1;
    localparam int PSR_SYS_RAPID = 0;
    // user interface flag bit positions
    localparam int PSR_UI_AUTO_RECAL_OFF = 4;
    localparam int PSR_UI_SENSE_OFF = 3;
    // reset values
    localparam logic [7:0] PSR_RST_MOVE_COMP = 8'h00;
    localparam logic [3:0] PSR_RST_COMP_MULT = 4'h0;
    localparam logic [7:0] PSR_RST_FLAGS = 8'h00;
    // a held engine reports no sync and no auto recalibration, so those bits start set
    localparam logic [7:0] PSR_RST_SYS_FLAGS = 8'h08;
    localparam logic [7:0] PSR_RST_USER_INTERFACE_FLAGS = 8'h10;
    localparam logic [31:0] PSR_UNMAPPED_DATA = 32'h0000_0000;
    // status inputs from the sensing engine
    typedef struct packed {
        logic bus_mode;
        logic tracking;
        logic movement_channel_on;
        logic sync_seen;
        logic shift_detected;
        logic halt_expired;
        logic recalibration_busy;
        logic rapid_debounce_active;
        logic sensing_disabled;
        logic auto_recalibration;
    } psr_status_t;
endpackage : psr_pkg

// File: logic/psr_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// R01: system flags bit 7 set while serial bus mode active, else clear.
// R02: system flags bit 6 set while advanced temperature tracking runs.
// R03: system flags bit 5 set while movement channel is activated.
// R04: bit 3 set when no sync input active; bit 4 reserved.
// R05: bit 2 set on proximity shift; auto clears after filter-halt time.
// R06: bit 1 set while either channel is recalibrating.
// R07: rapid-debounce flag set during fast debounce, cleared afterwards.
// R08: movement compensation multiplier field holds values zero to fifteen.
// R09: User_interface_flags bit 3 sensing disabled; bit 4 auto recalibration off.
// R10: flag bytes are read-only; host writes do not change them.
module psr_regs
    import psr_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // avalon-mm slave
    input wire logic [PSR_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // engine status, asynchronous to this clock
    input wire psr_status_t status_in,
    // compensation to the engine
    output logic [7:0] movement_comp_out,
    output logic [3:0] comp_mult_out
);
    psr_status_t status_meta_r;
    psr_status_t status_sync_r;
    logic [7:0] sys_flags_r;
    logic [7:0] user_interface_flags_r;
    logic [7:0] move_comp_r;
    logic [3:0] comp_mult_r;
    logic busy_r;
    logic [31:0] rdata_nxt;

    // two-stage synchroniser; engine runs on its own timebase
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_meta_r <= '0;
            status_sync_r <= '0;
        end else begin
            status_meta_r <= status_in;
            status_sync_r <= status_meta_r;
        end
    end

    // system flags follow the engine; no bus path reaches them
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // matches the all-zero synchroniser, so no false flag edge after reset
            sys_flags_r <= PSR_RST_SYS_FLAGS;
        end else begin
            sys_flags_r[PSR_SYS_BUS_MODE] <= status_sync_r.bus_mode; // see R01, see R10
            sys_flags_r[PSR_SYS_TRACKING] <= status_sync_r.tracking; // see R02
            sys_flags_r[PSR_SYS_MOVE_ON] <= status_sync_r.movement_channel_on; // see R03
            sys_flags_r[4] <= 1'b0; // reserved, see R04
            sys_flags_r[PSR_SYS_NO_SYNC] <= !status_sync_r.sync_seen; // see R04
            sys_flags_r[PSR_SYS_RECAL] <= status_sync_r.recalibration_busy; // see R06
            sys_flags_r[PSR_SYS_RAPID] <= status_sync_r.rapid_debounce_active; // see R07
            // halt is sticky until engine reports timeout; a new shift wins
            if (status_sync_r.shift_detected) begin
                sys_flags_r[PSR_SYS_BASE_HALT] <= 1'b1; // see R05
            end else if (status_sync_r.halt_expired) begin
                sys_flags_r[PSR_SYS_BASE_HALT] <= 1'b0; // see R05
            end
        end
    end

    // user interface flags
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // auto recalibration reads off while the synchroniser holds zero
            user_interface_flags_r <= PSR_RST_USER_INTERFACE_FLAGS;
        end else begin
            user_interface_flags_r <= PSR_RST_FLAGS;
            user_interface_flags_r[PSR_UI_SENSE_OFF] <= status_sync_r.sensing_disabled; // see R09
            user_interface_flags_r[PSR_UI_AUTO_RECAL_OFF] <= !status_sync_r.auto_recalibration; // see R09
        end
    end

    // writable compensation registers, low byte lane only
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            move_comp_r <= PSR_RST_MOVE_COMP;
            comp_mult_r <= PSR_RST_COMP_MULT;
        end else if (avs_write_in && !busy_r && avs_byteenable_in[0]) begin
            if (avs_address_in == PSR_ADDR_MOVE_COMP) begin
                move_comp_r <= avs_writedata_in[7:0];
            end
            if (avs_address_in == PSR_ADDR_COMP_MULT) begin
                comp_mult_r <= avs_writedata_in[3:0]; // 4 bits hold 0..15, see R08
            end
        end
    end

    // read mux; unmapped reads return zero
    always_comb begin
        rdata_nxt = PSR_UNMAPPED_DATA;
        case (avs_address_in)
            PSR_ADDR_COMP_MULT: rdata_nxt = {28'h000_0000, comp_mult_r};
            PSR_ADDR_MOVE_COMP: rdata_nxt = {24'h00_0000, move_comp_r};
            PSR_ADDR_SYS_FLAGS: rdata_nxt = {24'h00_0000, sys_flags_r};
            PSR_ADDR_USER_INTERFACE_FLAGS: rdata_nxt = {24'h00_0000, user_interface_flags_r};
            default: rdata_nxt = PSR_UNMAPPED_DATA;
        endcase
    end

    // one wait cycle per access so readdata comes from a flop
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_r <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            busy_r <= (avs_read_in || avs_write_in) && !busy_r;
            if (avs_read_in && !busy_r) begin
                avs_readdata_out <= rdata_nxt;
            end
        end
    end

    // waitrequest high at idle and first access cycle, low on the second
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_waitrequest_out <= 1'b1;
        end else begin
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !busy_r);
        end
    end

    // compensation outputs
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            movement_comp_out <= PSR_RST_MOVE_COMP;
            comp_mult_out <= PSR_RST_COMP_MULT;
        end else begin
            movement_comp_out <= move_comp_r;
            comp_mult_out <= comp_mult_r;
        end
    end

    a_bus_mode_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R01
        sys_flags_r[PSR_SYS_BUS_MODE] == $past(status_sync_r.bus_mode))
        else $error("bus mode flag does not follow input");
    a_tracking_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R02
        $rose(status_sync_r.tracking) |=> sys_flags_r[PSR_SYS_TRACKING])
        else $error("tracking flag late");
    a_move_on_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R03
        status_sync_r.movement_channel_on |=> sys_flags_r[PSR_SYS_MOVE_ON])
        else $error("movement flag missing");
    a_no_sync_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R04
        sys_flags_r[PSR_SYS_NO_SYNC] != $past(status_sync_r.sync_seen) && !sys_flags_r[4])
        else $error("no sync flag wrong");
    a_halt_set_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R05
        status_sync_r.shift_detected |=> sys_flags_r[PSR_SYS_BASE_HALT])
        else $error("halt flag not set");
    a_halt_hold_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R05
        !status_sync_r.shift_detected && !status_sync_r.halt_expired
        |=> $stable(sys_flags_r[PSR_SYS_BASE_HALT]))
        else $error("halt flag changed without cause");
    a_recal_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R06
        status_sync_r.recalibration_busy |=> sys_flags_r[PSR_SYS_RECAL])
        else $error("recalibration flag missing");
    a_rapid_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R07
        !status_sync_r.rapid_debounce_active |=> !sys_flags_r[PSR_SYS_RAPID])
        else $error("rapid debounce flag stuck");
    a_user_interface_flags_map: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R09
        status_sync_r.sensing_disabled && !status_sync_r.auto_recalibration
        |=> user_interface_flags_r[PSR_UI_SENSE_OFF] && user_interface_flags_r[PSR_UI_AUTO_RECAL_OFF])
        else $error("user_interface_flags wrong");
    a_mult_write: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R08
        avs_write_in && !busy_r && avs_byteenable_in[0] && avs_address_in == PSR_ADDR_COMP_MULT
        |=> comp_mult_r == $past(avs_writedata_in[3:0]) ##1 comp_mult_out == $past(comp_mult_r))
        else $error("multiplier write lost");
    a_flags_readonly: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R10
        avs_write_in && avs_address_in == PSR_ADDR_USER_INTERFACE_FLAGS
        |=> user_interface_flags_r[7:5] == 3'b000 && user_interface_flags_r[2:0] == 3'b000)
        else $error("flag byte changed by write");

    // flags must drop when their cause goes away; rapid flag rise, user bits and write immunity are also checked here
    a_tracking_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R02
        !status_sync_r.tracking |=> !sys_flags_r[PSR_SYS_TRACKING])
        else $error("tracking flag stuck");
    a_move_off_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R03
        !status_sync_r.movement_channel_on |=> !sys_flags_r[PSR_SYS_MOVE_ON])
        else $error("movement flag stuck");
    a_halt_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R05
        !status_sync_r.shift_detected && status_sync_r.halt_expired
        |=> !sys_flags_r[PSR_SYS_BASE_HALT])
        else $error("halt flag not cleared");
    a_recal_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R06
        !status_sync_r.recalibration_busy |=> !sys_flags_r[PSR_SYS_RECAL])
        else $error("recalibration flag stuck");
    a_rapid_set: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R07
        status_sync_r.rapid_debounce_active |=> sys_flags_r[PSR_SYS_RAPID])
        else $error("rapid debounce flag missing");
    a_ui_sense_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R09
        user_interface_flags_r[PSR_UI_SENSE_OFF] == $past(status_sync_r.sensing_disabled))
        else $error("sensing disabled flag wrong");
    a_ui_recal_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R09
        user_interface_flags_r[PSR_UI_AUTO_RECAL_OFF] != $past(status_sync_r.auto_recalibration))
        else $error("auto recalibration flag wrong");
    a_sys_readonly: assert property (@(posedge clk_in) disable iff (!rst_n_in) // see R10
        avs_write_in && avs_address_in == PSR_ADDR_SYS_FLAGS
        |=> sys_flags_r[PSR_SYS_MOVE_ON] == $past(status_sync_r.movement_channel_on)
        && !sys_flags_r[4])
        else $error("system flag byte changed by write");

    // bus timing: exactly one wait state, data registered at the taking edge
    a_wait_one: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    a_read_data: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        avs_read_in && !busy_r
        |=> avs_readdata_out == $past(rdata_nxt) && !avs_waitrequest_out)
        else $error("read data not presented with waitrequest low");
    a_move_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        avs_write_in && !busy_r && avs_byteenable_in[0] && avs_address_in == PSR_ADDR_MOVE_COMP
        |=> move_comp_r == $past(avs_writedata_in[7:0]))
        else $error("compensation write lost");
endmodule : psr_regs

// File: tb/psr_host.sv
`timescale 1ns/1ps
// host side of the register bus; holds each request until waitrequest is seen low
module psr_host
    import psr_pkg::*;
(
    // clock
    input wire logic clk_in,
    // bus towards the register bank
    output logic [PSR_ADDR_W-1:0] address_out,
    output logic read_out,
    output logic write_out,
    output logic [31:0] writedata_out,
    output logic [3:0] byteenable_out,
    input wire logic [31:0] readdata_in,
    input wire logic waitrequest_in
);
    // idle bus at time zero
    initial begin
        address_out = '0;
        read_out = 1'b0;
        write_out = 1'b0;
        writedata_out = '0;
        byteenable_out = 4'h0;
    end
    // one transfer; a hang here is cut short by the bench watchdog
    task automatic xfer(input logic wr, input logic [PSR_ADDR_W-1:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        @(posedge clk_in);
        read_out <= !wr;
        write_out <= wr;
        address_out <= a;
        writedata_out <= d;
        byteenable_out <= be;
        do @(posedge clk_in); while (waitrequest_in !== 1'b0);
        q = readdata_in;
        read_out <= 1'b0;
        write_out <= 1'b0;
        // released address and data never keep the old value; byteenable is left as it was
        address_out <= ~a;
        writedata_out <= ~d;
    endtask : xfer
endmodule : psr_host

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import psr_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [PSR_ADDR_W-1:0] adr;
    logic rd_s, wr_s, wt;
    logic [31:0] wd, rdd, q, v, rv;
    logic [3:0] be, mult;
    logic [7:0] comp;
    logic halt;
    psr_status_t status_in = '0;
    psr_status_t st;
    int num_errors = 0;
    int comparisons = 0;
    // 100 MHz clock
    always #5 clk_in = ~clk_in;
    psr_regs DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(adr),
        .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdd), .avs_waitrequest_out(wt),
        .status_in(status_in), .movement_comp_out(comp), .comp_mult_out(mult));
    psr_host host (.clk_in(clk_in), .address_out(adr), .read_out(rd_s), .write_out(wr_s),
        .writedata_out(wd), .byteenable_out(be), .readdata_in(rdd), .waitrequest_in(wt));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic wr(input logic [PSR_ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] e);
        host.xfer(1'b1, a, d, e, q);
    endtask : wr
    task automatic rd(input logic [PSR_ADDR_W-1:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0000_0000, 4'hf, q);
        chk(q, exp);
    endtask : rd
    // expected flag bytes; bit 4 of the system byte is reserved and reads zero
    function automatic logic [31:0] exp_sys(input psr_status_t s, input logic h);
        return {24'h00_0000, s.bus_mode, s.tracking, s.movement_channel_on, 1'b0,
            !s.sync_seen, h, s.recalibration_busy, s.rapid_debounce_active};
    endfunction : exp_sys
    function automatic logic [31:0] exp_ui(input psr_status_t s);
        return {27'h000_0000, !s.auto_recalibration, s.sensing_disabled, 3'h0};
    endfunction : exp_ui
    // watchdog sized well above the few hundred cycles the tests need
    initial begin
        #200us;
        num_errors++;
        conclude();
    end
    // main sequence
    initial begin
        rv = $urandom(32'he292_304a);
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(PSR_ADDR_MOVE_COMP, {24'h00_0000, PSR_RST_MOVE_COMP});
        rd(PSR_ADDR_COMP_MULT, {28'h000_0000, PSR_RST_COMP_MULT});
        v = $urandom;
        wr(PSR_ADDR_MOVE_COMP, v, 4'h1);
        rd(PSR_ADDR_MOVE_COMP, {24'h00_0000, v[7:0]});
        chk({24'h00_0000, comp}, {24'h00_0000, v[7:0]});
        // lane 0 off and an unmapped write must both leave the byte alone
        wr(PSR_ADDR_MOVE_COMP, ~v, 4'he);
        wr(10'h3fc, ~v, 4'hf);
        rd(PSR_ADDR_MOVE_COMP, {24'h00_0000, v[7:0]});
        rd(10'h3fc, PSR_UNMAPPED_DATA);
        // multiplier limits and one random value
        for (int i = 0; i < 3; i++) begin
            rv = $urandom;
            v = (i == 0) ? 32'h0000_000f : (i == 1) ? 32'h0000_0000 : {28'h000_0000, rv[3:0]};
            wr(PSR_ADDR_COMP_MULT, v, 4'h1);
            rd(PSR_ADDR_COMP_MULT, v);
            chk({28'h000_0000, mult}, v);
        end
        // status flags: corners first, then random, with host writes that must not land
        halt = 1'b0;
        for (int i = 0; i < 24; i++) begin
            rv = $urandom;
            st = (i == 0) ? '1 : (i == 1) ? '0 : rv[9:0];
            if (st.shift_detected) halt = 1'b1;
            else if (st.halt_expired) halt = 1'b0;
            @(posedge clk_in);
            status_in <= st;
            wr(PSR_ADDR_SYS_FLAGS, ~exp_sys(st, halt), 4'hf);
            wr(PSR_ADDR_USER_INTERFACE_FLAGS, ~exp_ui(st), 4'hf);
            repeat (4) @(posedge clk_in);
            rd(PSR_ADDR_SYS_FLAGS, exp_sys(st, halt));
            rd(PSR_ADDR_USER_INTERFACE_FLAGS, exp_ui(st));
        end
        conclude();
    end
endmodule : tb_top
